// ===== rtl/scr_pkg.sv
// Constants for the three-phase slope compensation register bank.
// Assumes a 25 MHz controller clock and a command decoder on that clock.
//
// Contract
// - Unused upper bits ignore writes, read zero.
// - Capacitor code from rate bits 9:6.
// - Charging current code from rate bits 5:0.
// - D6h/D7h apply only with three phases.
// - Limit reached: current off, voltage held.
// - Ramp limit is bits 7:0, 5 ns steps.
package scr_pkg;
  // Command codes of the two registers
  localparam logic [7:0] SCR_CMD_RATE_3P = 8'hd6;
  localparam logic [7:0] SCR_CMD_LIMIT_3P = 8'hd7;
  // Register and field layout
  localparam int SCR_REG_W = 16;
  localparam int SCR_RATE_W = 10;
  localparam int SCR_LIMIT_W = 8;
  localparam int SCR_CAP_LSB = 6;
  localparam int SCR_CAP_W = 4;
  localparam int SCR_CUR_LSB = 0;
  localparam int SCR_CUR_W = 6;
  // Reset values
  localparam logic [SCR_RATE_W-1:0] SCR_RATE_RST = 10'h000;
  localparam logic [SCR_LIMIT_W-1:0] SCR_LIMIT_RST = 8'h00;
  // Timing: clock period and limit step, both in ns
  localparam int SCR_CLK_PERIOD_NS = 40;
  localparam int SCR_STEP_NS = 5;
  // Steps elapsed per clock, rounded down, never below one
  localparam int SCR_STEPS_PER_CLK_I = (SCR_CLK_PERIOD_NS / SCR_STEP_NS) < 1 ? 1
                                       : (SCR_CLK_PERIOD_NS / SCR_STEP_NS);
  localparam int SCR_ELAPSED_W = 10;
  localparam logic [SCR_ELAPSED_W-1:0] SCR_STEPS_PER_CLK = SCR_ELAPSED_W'(SCR_STEPS_PER_CLK_I);
  // Ramp states, one-hot
  typedef enum logic [2:0]
  {
    SCR_IDLE = 3'b001,
    SCR_RAMP = 3'b010,
    SCR_HOLD = 3'b100
  } scr_state_e;
endpackage

// ===== rtl/scr_slope_regs.sv
// Three-phase slope compensation registers and ramp-duration limiter.
// Assumes command code, strobes and phase status come from logic on i_ref_clk.
`timescale 1ns/100ps
module scr_slope_regs
(
  input wire logic i_ref_clk, // Controller clock
  input wire logic i_resetn, // Asynchronous reset, active low
  input wire logic [7:0] i_cmd_code, // Command code of the access
  input wire logic i_wr_stb, // One-cycle write strobe
  input wire logic [scr_pkg::SCR_REG_W-1:0] i_wr_data, // Write word
  input wire logic i_rd_stb, // One-cycle read strobe
  input wire logic i_three_phase, // Controller runs three phases
  input wire logic i_ramp_start, // Blanking ended, new ramp begins
  output logic [scr_pkg::SCR_REG_W-1:0] o_rd_data, // Read word
  output logic [scr_pkg::SCR_CAP_W-1:0] o_ramp_cap_select, // Ramp capacitor code
  output logic [scr_pkg::SCR_CUR_W-1:0] o_ramp_current_code, // Ramp current code
  output logic o_ramp_current_en, // Ramp current source on
  output logic o_slope_hold // Slope voltage held
);
  import scr_pkg::*;

  // Register storage
  logic [SCR_RATE_W-1:0] rate_q, rate_d; // Rate register, used bits only
  logic [SCR_LIMIT_W-1:0] limit_q, limit_d; // Limit register, used bits only
  logic [SCR_REG_W-1:0] rd_data_d; // Next read word
  // Ramp control state
  scr_state_e state_q, state_d; // Ramp state
  logic [SCR_ELAPSED_W-1:0] elapsed_q, elapsed_d; // Steps since ramp start
  logic [SCR_ELAPSED_W-1:0] elapsed_inc; // Steps after this clock
  // Output registers
  logic [SCR_CAP_W-1:0] cap_d; // Next capacitor code
  logic [SCR_CUR_W-1:0] cur_d; // Next current code
  logic en_d; // Next source enable
  logic hold_d; // Next hold flag

  // Register writes and read data
  always_comb
  begin
    rate_d = rate_q;
    limit_d = limit_q;
    rd_data_d = o_rd_data;
    if (i_wr_stb && i_cmd_code == SCR_CMD_RATE_3P)
    begin
      // Upper bits dropped on write
      rate_d = i_wr_data[SCR_RATE_W-1:0];
    end
    if (i_wr_stb && i_cmd_code == SCR_CMD_LIMIT_3P)
    begin
      limit_d = i_wr_data[SCR_LIMIT_W-1:0];
    end
    if (i_rd_stb)
    begin
      // Zero-extended words, unmapped codes read zero
      unique case (i_cmd_code)
        SCR_CMD_RATE_3P: rd_data_d = {{(SCR_REG_W-SCR_RATE_W){1'b0}}, rate_q};
        SCR_CMD_LIMIT_3P: rd_data_d = {{(SCR_REG_W-SCR_LIMIT_W){1'b0}}, limit_q};
        default: rd_data_d = 16'h0000;
      endcase
    end
  end

  // Register storage flops
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rate_q <= SCR_RATE_RST;
      limit_q <= SCR_LIMIT_RST;
      o_rd_data <= 16'h0000;
    end
    else
    begin
      rate_q <= rate_d;
      limit_q <= limit_d;
      o_rd_data <= rd_data_d;
    end
  end

  // Ramp timer: counts steps and stops the source at the limit
  always_comb
  begin
    state_d = state_q;
    elapsed_d = elapsed_q;
    elapsed_inc = elapsed_q + SCR_STEPS_PER_CLK;
    if (!i_three_phase)
    begin
      // Settings are not ours outside three-phase operation
      state_d = SCR_IDLE;
      elapsed_d = 10'h000;
    end
    else if (i_ramp_start)
    begin
      // Each ramp restarts the count, and the source unless the limit is zero
      elapsed_d = 10'h000;
      state_d = (limit_q == 8'h00) ? SCR_HOLD : SCR_RAMP;
    end
    else
    begin
      unique case (state_q)
        SCR_IDLE: state_d = SCR_IDLE;
        SCR_RAMP:
        begin
          elapsed_d = elapsed_inc;
          if (elapsed_inc >= {2'b00, limit_q})
          begin
            state_d = SCR_HOLD;
          end
        end
        SCR_HOLD: state_d = SCR_HOLD;
        default: state_d = SCR_IDLE;
      endcase
    end
  end

  // Enable and hold follow the next state, codes follow the rate register, so each output is a flop
  always_comb
  begin
    cap_d = i_three_phase ? rate_q[SCR_CAP_LSB +: SCR_CAP_W] : 4'h0;
    cur_d = i_three_phase ? rate_q[SCR_CUR_LSB +: SCR_CUR_W] : 6'h00;
    en_d = (state_d == SCR_RAMP);
    hold_d = (state_d == SCR_HOLD);
  end

  // Ramp state and output flops
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= SCR_IDLE;
      elapsed_q <= 10'h000;
      o_ramp_cap_select <= 4'h0;
      o_ramp_current_code <= 6'h00;
      o_ramp_current_en <= 1'b0;
      o_slope_hold <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      elapsed_q <= elapsed_d;
      o_ramp_cap_select <= cap_d;
      o_ramp_current_code <= cur_d;
      o_ramp_current_en <= en_d;
      o_slope_hold <= hold_d;
    end
  end

  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  // A ramp being started with a nonzero limit
  sequence s_start;
    i_ramp_start && i_three_phase && limit_q != 8'h00;
  endsequence

  // Source running with the counter freshly cleared
  sequence s_ramping;
    o_ramp_current_en && !o_slope_hold && elapsed_q == 10'h000;
  endsequence

  chk_reserved_read_zero: assert property (
    i_rd_stb && i_cmd_code == SCR_CMD_RATE_3P |=> o_rd_data[15:10] == 6'h00)
    else $error("rate register upper bits not zero");
  chk_limit_read_zero: assert property (
    i_rd_stb && i_cmd_code == SCR_CMD_LIMIT_3P |=> o_rd_data[15:8] == 8'h00)
    else $error("limit register upper bits not zero");
  chk_cap_field_out: assert property (
    i_wr_stb && i_cmd_code == SCR_CMD_RATE_3P ##1 i_three_phase [*2]
    |-> o_ramp_cap_select == $past(i_wr_data[9:6], 2))
    else $error("capacitor code not taken from bits 9:6");
  chk_cur_field_out: assert property (
    i_wr_stb && i_cmd_code == SCR_CMD_RATE_3P ##1 i_three_phase [*2]
    |-> o_ramp_current_code == $past(i_wr_data[5:0], 2))
    else $error("current code not taken from bits 5:0");
  chk_not_three_phase: assert property (
    !i_three_phase |=> !o_ramp_current_en && !o_slope_hold && o_ramp_cap_select == 4'h0
                       && o_ramp_current_code == 6'h00)
    else $error("settings applied outside three-phase operation");
  chk_limit_stops_ramp: assert property (
    state_q == SCR_RAMP && i_three_phase && !i_ramp_start && elapsed_inc >= {2'b00, limit_q}
    |=> !o_ramp_current_en && o_slope_hold)
    else $error("source not stopped at limit");
  chk_hold_at_limit: assert property (
    $rose(o_slope_hold) && $past(state_q) == SCR_RAMP && !$past(i_ramp_start)
    |-> elapsed_q >= {2'b00, $past(limit_q)} && elapsed_q - SCR_STEPS_PER_CLK < {2'b00, $past(limit_q)})
    else $error("ramp stopped off its 5 ns limit");
  chk_ramp_restart: assert property (
    s_start |=> s_ramping)
    else $error("ramp not restarted");
  // Rate write stores the used bits, upper bits dropped
  chk_rate_store: assert property (
    i_wr_stb && i_cmd_code == SCR_CMD_RATE_3P |=> rate_q == $past(i_wr_data[SCR_RATE_W-1:0]))
    else $error("rate register not stored");
  // Limit write stores the 8-bit step count
  chk_limit_store: assert property (
    i_wr_stb && i_cmd_code == SCR_CMD_LIMIT_3P |=> limit_q == $past(i_wr_data[SCR_LIMIT_W-1:0]))
    else $error("limit register not stored");
  // Writes to any other code leave both registers alone
  chk_other_code_ignored: assert property (
    i_wr_stb && i_cmd_code != SCR_CMD_RATE_3P && i_cmd_code != SCR_CMD_LIMIT_3P
    |=> $stable(rate_q) && $stable(limit_q))
    else $error("write to another code changed a register");
  // Rate read returns the stored capacitor and current fields
  chk_rate_read_back: assert property (
    i_rd_stb && i_cmd_code == SCR_CMD_RATE_3P |=> o_rd_data[SCR_RATE_W-1:0] == $past(rate_q))
    else $error("rate register read back wrong");
  // Limit read returns the stored step count
  chk_limit_read_back: assert property (
    i_rd_stb && i_cmd_code == SCR_CMD_LIMIT_3P |=> o_rd_data[SCR_LIMIT_W-1:0] == $past(limit_q))
    else $error("limit register read back wrong");
  // A held slope stays held until the next ramp or a phase change
  chk_hold_stays: assert property (
    o_slope_hold && i_three_phase && !i_ramp_start |=> o_slope_hold && !o_ramp_current_en)
    else $error("slope hold dropped without a new ramp");
  // Zero limit: the source never runs, the slope is held at once
  chk_zero_limit_hold: assert property (
    i_ramp_start && i_three_phase && limit_q == 8'h00 |=> o_slope_hold && !o_ramp_current_en)
    else $error("zero limit still ran the ramp");
  // Below the limit the source keeps running
  chk_ramp_runs_on: assert property (
    state_q == SCR_RAMP && i_three_phase && !i_ramp_start && elapsed_inc < {2'b00, limit_q}
    |=> o_ramp_current_en && !o_slope_hold)
    else $error("source stopped before the limit");
endmodule

// ===== dv/scr_host.sv
// Host software model: drives the management bus of the slope registers.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/100ps
module scr_host
(
  input wire logic i_clk, // Bus clock
  output logic [7:0] o_code, // Command code
  output logic o_wr, // Write strobe
  output logic o_rd, // Read strobe
  output logic [15:0] o_data // Write word
);
  // One bus cycle, changed at the falling edge and held to the next one
  task automatic acc(input logic w, input logic r, input logic [7:0] c, input logic [15:0] d);
    o_wr = w;
    o_rd = r;
    o_code = c;
    o_data = d;
    @(negedge i_clk);
  endtask
  // Limit in 5 ns steps from switching period and blanking time in ns
  function automatic int limit_for(int tsw, int blank);
    return 13 * (tsw / 3 - blank) / 50;
  endfunction
  // Target slope voltage, doubled under half sense gain
  function automatic int target_for(int v, bit half);
    return half ? 2 * v : v;
  endfunction
endmodule

// ===== dv/slope_comp_three_phase_regs_bench.sv
// Self-checking bench for the three-phase slope registers and ramp limiter.
// Assumes the host model drives the bus; reads are scored from a queue.
`timescale 1ns/100ps
module slope_comp_three_phase_regs_bench;
  import scr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, three = 1'b1, start = 1'b0, pend = 1'b0;
  logic [7:0] code;
  logic wr, rd, en, hold;
  logic [15:0] wdata, rdata, rate_m = 16'h0000, lim_m = 16'h0000;
  logic [3:0] cap;
  logic [5:0] cur;
  logic [15:0] exp_q[$]; // Expected read words, oldest first
  int bad_count = 0, tests_run = 0, n, r;
  int lims[6] = '{0, 1, 8, 9, 0, 0}; // Ramp limits tried in turn
  always #20 clk = ~clk;
  scr_host i_scr_host (.i_clk(clk), .o_code(code), .o_wr(wr), .o_rd(rd), .o_data(wdata));
  scr_slope_regs i_scr_slope_regs (.i_ref_clk(clk), .i_resetn(rst_n), .i_cmd_code(code), .i_wr_stb(wr),
    .i_wr_data(wdata), .i_rd_stb(rd), .i_three_phase(three), .i_ramp_start(start), .o_rd_data(rdata),
    .o_ramp_cap_select(cap), .o_ramp_current_code(cur), .o_ramp_current_en(en), .o_slope_hold(hold));
  // Compares one value and reports a mismatch
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Register write, mirrored into the bench's copy
  task automatic wr_reg(logic [7:0] c, logic [15:0] d);
    i_scr_host.acc(1'b1, 1'b0, c, d);
    if (c == SCR_CMD_RATE_3P) rate_m = d & 16'h03ff;
    if (c == SCR_CMD_LIMIT_3P) lim_m = d & 16'h00ff;
  endtask
  // Register read; expected word queued for the monitor
  task automatic rd_reg(logic [7:0] c);
    exp_q.push_back(c == SCR_CMD_RATE_3P ? rate_m : c == SCR_CMD_LIMIT_3P ? lim_m : 16'h0000);
    i_scr_host.acc(1'b0, 1'b1, c, 16'h0000);
  endtask
  task automatic idle(int k);
    repeat (k) i_scr_host.acc(1'b0, 1'b0, 8'h00, 16'h0000);
  endtask
  // Monitor: read word settles one cycle after the strobe edge
  always @(posedge clk) pend <= rd;
  always @(negedge clk)
    if (pend) check("rd_data", rdata, exp_q.pop_front());
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #200000;
    bad_count++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    idle(3);
    rst_n = 1'b1;
    r = $urandom(32'h03f8);
    rd_reg(SCR_CMD_RATE_3P);
    rd_reg(SCR_CMD_LIMIT_3P);
    repeat (4)
    begin
      wr_reg(SCR_CMD_RATE_3P, 16'($urandom));
      wr_reg(SCR_CMD_LIMIT_3P, 16'($urandom));
      wr_reg(8'hd5, 16'($urandom)); // Other code: ignored
      rd_reg(SCR_CMD_RATE_3P);
      rd_reg(8'hd5);
      rd_reg(SCR_CMD_LIMIT_3P);
      idle(1);
      check("cap", 16'(cap), 16'(rate_m[9:6]));
      check("cur", 16'(cur), 16'(rate_m[5:0]));
    end
    // Half sense gain: software doubles the target before coding it
    wr_reg(SCR_CMD_RATE_3P, 16'(i_scr_host.target_for(12, 1'b1)));
    idle(1);
    check("cur_half_gain", 16'(cur), 16'h0018);
    lims[4] = i_scr_host.limit_for(3000, 200);
    // Each ramp restarts the limiter; last pass runs outside three-phase
    foreach (lims[k])
    begin
      three = (k != 5);
      wr_reg(SCR_CMD_LIMIT_3P, 16'(lims[k]));
      start = 1'b1;
      idle(1);
      start = 1'b0;
      n = 0;
      while (en === 1'b1 && n < 300)
      begin
        n++;
        idle(1);
      end
      check("ramp_cycles", 16'(n), k == 5 ? 16'h0000 : 16'((lims[k] + 7) / 8));
      check("hold", 16'(hold), 16'(k != 5));
    end
    check("cap_off", 16'(cap), 16'h0000);
    check("cur_off", 16'(cur), 16'h0000);
    complete_run();
  end
endmodule
